//--- flash_array_model.sv
// Flash array stand-in: answers each command of nonzero latency with a done pulse
`timescale 1ns/100ps

module flash_array_model
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       flash_cmd_valid,
  input wire logic [7:0] latency,
  output logic           flash_cmd_done
);
  logic [7:0] count_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      count_reg      <= 8'h00;
      flash_cmd_done <= 1'b0;
    end
    else
    begin
      count_reg      <= flash_cmd_valid ? latency : (count_reg != 8'h00 ? count_reg - 8'h01 : 8'h00);
      flash_cmd_done <= count_reg == 8'h01;
    end
  end
endmodule : flash_array_model

//--- flash_self_program_asserts.sv
// Concurrent checks on the flash self-programming controller ports
`timescale 1ns/100ps

module flash_self_program_asserts
  import flash_self_program_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        flash_cmd_valid,
  input wire logic [1:0]  flash_cmd_func,
  input wire logic [16:0] flash_cmd_addr,
  input wire logic        flash_cmd_done,
  input wire logic        pc_hold,
  input wire logic        data_flash_enable,
  input wire logic        self_program_enable
);
  wire mapped = sfr_addr == ADDR_SYSTEM_CONTROL || sfr_addr[7:2] == 6'h3D;
  wire start_req = sfr_wr && sfr_addr == ADDR_FLASH_OP_CTRL && sfr_wdata[BIT_OP_START];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence start_taken;
    start_req ##1 flash_cmd_valid;
  endsequence

  map_hit_a: assert property ((sfr_wr || sfr_rd) && mapped |=> sfr_hit)
    else $error("mapped access without hit");
  unmapped_zero_a: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("unmapped read answered");
  cmd_hold_a: assert property (flash_cmd_valid |-> pc_hold)
    else $error("command without counter hold");
  valid_pulse_a: assert property (flash_cmd_valid |=> !flash_cmd_valid)
    else $error("command valid longer than one cycle");
  cmd_cause_a: assert property (flash_cmd_valid |-> $past(start_req))
    else $error("command without start write");
  hold_release_a: assert property (pc_hold && $past(pc_hold) && flash_cmd_done |=> !pc_hold)
    else $error("hold not released after done");
  hold_stays_a: assert property (pc_hold && !flash_cmd_done |=> pc_hold)
    else $error("hold dropped before done");
  disabled_start_a: assert property (start_req && !self_program_enable |=> !flash_cmd_valid)
    else $error("start taken while disabled");
  cmd_fields_a: assert property (start_taken |-> flash_cmd_func == $past(sfr_wdata[1:0])
    && (flash_cmd_func == FUNC_FULL_ERASE ? flash_cmd_addr == 17'h0_0000
        : flash_cmd_addr[16] == $past(sfr_wdata[5])))
    else $error("command fields differ from control write");
  dflash_reset_a: assert property ($rose(rst_n) |-> !data_flash_enable)
    else $error("data flash enabled out of reset");
endmodule : flash_self_program_asserts

bind flash_self_program_ctrl flash_self_program_asserts u_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .flash_cmd_valid(flash_cmd_valid), .flash_cmd_func(flash_cmd_func),
  .flash_cmd_addr(flash_cmd_addr), .flash_cmd_done(flash_cmd_done), .pc_hold(pc_hold),
  .data_flash_enable(data_flash_enable), .self_program_enable(self_program_enable));

//--- flash_self_program_ctrl.sv
// Flash self-programming controller behind the special function registers
//
// Function
// R1: Watchdog reset sets status bit seven
// R2: Bit three enables data flash, off after reset
// R3: Bit two enables self programming
// R4: Bit one enables extra 768 byte RAM
// R5: Bit zero inhibits address latch strobe clock
// R6: High and low registers form flash address
// R7: Data register holds operation byte
// R8: Control: start bit7, zone bit5, function bits1:0
// R9: Zone bit is seventeenth flash address bit
// R10: Start bit begins operation; clear means none
// R11: Function codes select program, protect, page, full erase
// R12: Full erase spares locked boot region
// R13: Start bit read-only until unlock sequence
// R14: Software writes 55h, AAh, 55h before starting
// R15: Start captures address and data registers
// R16: Program counter held during operation
// R17: Completion clears start bit, releases counter
// R18: Software orders unlock, enable, load, start
// R19: Page erase clears 512 byte page
// R20: Start ignored while self programming disabled
// R21: Unused control bits read zero, ignore writes
`timescale 1ns/100ps

module flash_self_program_ctrl
  import flash_self_program_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Special function register port from the core
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // Reset cause from the watchdog timer
  input  wire logic        watchdog_timer_reset,
  // Boot lock configuration
  input  wire logic        boot_lock_active,
  input  wire logic [16:0] boot_region_base,
  // Flash array command port
  output logic             flash_cmd_valid,
  output logic [1:0]       flash_cmd_func,
  output logic [16:0]      flash_cmd_addr,
  output logic [16:0]      flash_cmd_last,
  output logic [7:0]       flash_cmd_data,
  input  wire logic        flash_cmd_done,
  // Core and chip controls
  output logic             pc_hold,
  output logic             data_flash_enable,
  output logic             extra_ram_enable,
  output logic             latch_strobe_inhibit,
  output logic             self_program_enable
);

  ////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]     flash_addr_high_reg;
  logic [7:0]     flash_addr_low_reg;
  logic [7:0]     flash_write_data_reg;
  logic           watchdog_reset_flag_reg;
  logic           data_flash_enable_reg;
  logic           self_program_enable_reg;
  logic           extra_ram_enable_reg;
  logic           latch_strobe_inhibit_reg;
  logic           op_start_bit_reg;
  logic           flash_zone_select_reg;
  logic [1:0]     op_function_code_reg;
  unlock_state_t  unlock_reg;
  unlock_state_t  unlock_next;
  seq_state_t     state_reg;
  seq_state_t     state_next;
  logic [7:0]     sfr_rdata_reg;
  logic           sfr_hit_reg;

  ////////////////////////////////////////////////////////////////////
  // Address decode

  wire sel_sys  = (sfr_addr == ADDR_SYSTEM_CONTROL);
  wire sel_ahi  = (sfr_addr == ADDR_FLASH_ADDR_HI);
  wire sel_alo  = (sfr_addr == ADDR_FLASH_ADDR_LO);
  wire sel_data = (sfr_addr == ADDR_FLASH_DATA);
  wire sel_ctrl = (sfr_addr == ADDR_FLASH_OP_CTRL);
  wire sel_any  = sel_sys | sel_ahi | sel_alo | sel_data | sel_ctrl;

  wire wr_sys   = sfr_wr & sel_sys;
  wire wr_ahi   = sfr_wr & sel_ahi;
  wire wr_alo   = sfr_wr & sel_alo;
  wire wr_data  = sfr_wr & sel_data;
  wire wr_ctrl  = sfr_wr & sel_ctrl;

  wire busy     = (state_reg != ST_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Unlock sequence tracking

  wire key_a = (sfr_wdata == UNLOCK_KEY_A);
  wire key_b = (sfr_wdata == UNLOCK_KEY_B);

  always_comb
  begin
    unlock_next = unlock_reg;
    if (wr_data)
    begin
      unique case (unlock_reg)
        UL_NONE: unlock_next = key_a ? UL_ONE : UL_NONE;
        UL_ONE:  unlock_next = key_b ? UL_TWO : (key_a ? UL_ONE : UL_NONE);
        UL_TWO:  unlock_next = key_a ? UL_OPEN : UL_NONE;
        UL_OPEN: unlock_next = UL_OPEN;
      endcase
    end
    if (wr_ctrl)
      unlock_next = UL_NONE;
  end

  // Start accepted only when unlocked, enabled and idle
  wire start_req  = wr_ctrl & sfr_wdata[BIT_OP_START]; // R10
  wire start_ok   = start_req & (unlock_reg == UL_OPEN) // R13
                  & self_program_enable_reg & ~busy;    // R20

  ////////////////////////////////////////////////////////////////////
  // Operation address range

  wire        flash_zone_select_next_w = sfr_wdata[BIT_ZONE_SELECT];
  wire [7:0]  sfr_addr_hi_cap = flash_addr_high_reg;
  wire [16:0] cap_addr = {flash_zone_select_next_w, sfr_addr_hi_cap, flash_addr_low_reg}; // R6 R9
  wire [1:0]  func_w   = sfr_wdata[BIT_FUNC_HI:BIT_FUNC_LO];

  // Page erase covers the even/odd high-byte pair
  localparam logic [16:0] PAGE_MASK = 17'(PAGE_BYTES - 1);
  wire [16:0] page_base = cap_addr & ~PAGE_MASK;            // R19
  wire [16:0] page_last = cap_addr | PAGE_MASK;             // R19
  wire        in_boot   = boot_lock_active & ~flash_zone_select_next_w
                        & (page_base >= boot_region_base);
  // Full erase stops short of a locked boot region
  wire [16:0] full_last = boot_lock_active
                        ? (boot_region_base - 17'd1) : 17'h1_FFFF; // R12
  wire        blocked   = (func_w == FUNC_PAGE_ERASE) & in_boot;   // R19

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  // Refused boot page erase stays idle, no done will follow
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start_ok & ~blocked) state_next = ST_ISSUE; // R19
      ST_ISSUE: state_next = ST_WAIT;
      ST_WAIT:  if (flash_cmd_done) state_next = ST_DONE;
      ST_DONE:  state_next = ST_IDLE;
    endcase
  end

  logic [16:0] cmd_addr_w;
  logic [16:0] cmd_last_w;
  always_comb
  begin
    cmd_addr_w = cap_addr;
    cmd_last_w = cap_addr;
    unique case (op_function_code_t'(func_w)) // R11
      FUNC_BYTE_PROGRAM: cmd_last_w = cap_addr;
      FUNC_ERASE_PROT:   cmd_last_w = cap_addr;
      FUNC_PAGE_ERASE:
      begin
        cmd_addr_w = page_base;
        cmd_last_w = page_last;
      end
      FUNC_FULL_ERASE:
      begin
        cmd_addr_w = 17'h0_0000;
        cmd_last_w = full_last;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flash_addr_high_reg      <= RESET_BYTE;
      flash_addr_low_reg       <= RESET_BYTE;
      flash_write_data_reg     <= RESET_BYTE;
      data_flash_enable_reg    <= RESET_SYSTEM_CONTROL[BIT_DATA_FLASH_EN]; // R2
      self_program_enable_reg  <= RESET_SYSTEM_CONTROL[BIT_SELF_PROG_EN];
      extra_ram_enable_reg     <= RESET_SYSTEM_CONTROL[BIT_EXTRA_RAM_EN];
      latch_strobe_inhibit_reg <= RESET_SYSTEM_CONTROL[BIT_STROBE_INHIBIT];
      op_start_bit_reg         <= 1'b0;
      flash_zone_select_reg    <= 1'b0;
      op_function_code_reg     <= 2'b00;
      unlock_reg               <= UL_NONE;
      state_reg                <= ST_IDLE;
    end
    else
    begin
      unlock_reg <= unlock_next;
      state_reg  <= state_next;
      if (wr_ahi)
        flash_addr_high_reg <= sfr_wdata; // R6
      if (wr_alo)
        flash_addr_low_reg <= sfr_wdata;
      if (wr_data)
        flash_write_data_reg <= sfr_wdata; // R7
      if (wr_sys)
      begin
        data_flash_enable_reg    <= sfr_wdata[BIT_DATA_FLASH_EN];  // R2
        self_program_enable_reg  <= sfr_wdata[BIT_SELF_PROG_EN];   // R3
        extra_ram_enable_reg     <= sfr_wdata[BIT_EXTRA_RAM_EN];   // R4
        latch_strobe_inhibit_reg <= sfr_wdata[BIT_STROBE_INHIBIT]; // R5
      end
      if (wr_ctrl & ~busy)
      begin
        flash_zone_select_reg <= sfr_wdata[BIT_ZONE_SELECT]; // R8
        op_function_code_reg  <= func_w;
      end
      if (start_ok & ~blocked)
        op_start_bit_reg <= 1'b1;   // R10
      else if (state_reg == ST_DONE)
        op_start_bit_reg <= 1'b0;   // R17
    end
  end

  // Watchdog cause must stand while rst_n is low; other resets clear
  always_ff @(posedge clk_sys)
  begin
    if (watchdog_timer_reset)
      watchdog_reset_flag_reg <= 1'b1; // R1
    else if (!rst_n)
      watchdog_reset_flag_reg <= RESET_SYSTEM_CONTROL[BIT_WATCHDOG_RESET];
    else if (wr_sys & ~sfr_wdata[BIT_WATCHDOG_RESET])
      watchdog_reset_flag_reg <= 1'b0;
  end

  // Flash command: captured at start, pulse on issue
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flash_cmd_valid <= 1'b0;
      flash_cmd_func  <= 2'b00;
      flash_cmd_addr  <= 17'h0_0000;
      flash_cmd_last  <= 17'h0_0000;
      flash_cmd_data  <= RESET_BYTE;
      pc_hold         <= 1'b0;
    end
    else
    begin
      flash_cmd_valid <= start_ok & ~blocked;
      if (start_ok)
      begin
        flash_cmd_func <= func_w;         // R11
        flash_cmd_addr <= cmd_addr_w;     // R15
        flash_cmd_last <= cmd_last_w;     // R12
        flash_cmd_data <= flash_write_data_reg; // R15
      end
      if (start_ok & ~blocked)
        pc_hold <= 1'b1;                  // R16
      else if (state_reg == ST_WAIT && flash_cmd_done)
        pc_hold <= 1'b0;                  // R17
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path, registered

  wire [7:0] sys_view  = {watchdog_reset_flag_reg, 3'b000, data_flash_enable_reg,
                          self_program_enable_reg, extra_ram_enable_reg,
                          latch_strobe_inhibit_reg}; // R21
  wire [7:0] ctrl_view = {op_start_bit_reg, 1'b0, flash_zone_select_reg,
                          3'b000, op_function_code_reg}; // R21
  wire [7:0] rd_mux    = sel_sys  ? sys_view
                       : sel_ahi  ? flash_addr_high_reg
                       : sel_alo  ? flash_addr_low_reg
                       : sel_data ? flash_write_data_reg
                       : sel_ctrl ? ctrl_view
                       : 8'h00_00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sfr_rdata_reg <= 8'h00_00;
      sfr_hit_reg   <= 1'b0;
    end
    else
    begin
      sfr_rdata_reg <= sfr_rd ? rd_mux : 8'h00_00;
      sfr_hit_reg   <= (sfr_rd | sfr_wr) & sel_any;
    end
  end

  assign sfr_rdata            = sfr_rdata_reg;
  assign sfr_hit              = sfr_hit_reg;
  assign data_flash_enable    = data_flash_enable_reg;
  assign self_program_enable  = self_program_enable_reg;
  assign extra_ram_enable     = extra_ram_enable_reg;
  assign latch_strobe_inhibit = latch_strobe_inhibit_reg;

endmodule : flash_self_program_ctrl

//--- flash_self_program_ctrl_tb.sv
// Register-level testbench for the flash self-programming controller
`timescale 1ns/100ps

module flash_self_program_ctrl_tb import flash_self_program_pkg::*;;
  logic        clk_sys, rst_n, sfr_wr, sfr_rd, wdt_rst, done, valid, pc_hold, hit;
  logic        dfe, spe, xre, lsi, lock;
  localparam logic [16:0] BOOT_BASE = 17'h0_F000;
  logic [7:0]  sfr_addr, sfr_wdata, rdata, cdata, lat;
  logic [1:0]  cfunc;
  logic [16:0] caddr, clast;
  logic [43:0] cap;
  logic [7:0]  regs [5] = '{8'h00_BF, 8'h00_F4, 8'h00_F5, 8'h00_F6, 8'h00_F7};
  int          err_total, checks_done, ops_seen, i;

  flash_self_program_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata),
    .sfr_hit(hit), .watchdog_timer_reset(wdt_rst), .boot_lock_active(lock),
    .boot_region_base(BOOT_BASE), .flash_cmd_valid(valid), .flash_cmd_func(cfunc),
    .flash_cmd_addr(caddr), .flash_cmd_last(clast), .flash_cmd_data(cdata),
    .flash_cmd_done(done), .pc_hold(pc_hold), .data_flash_enable(dfe),
    .extra_ram_enable(xre), .latch_strobe_inhibit(lsi), .self_program_enable(spe));
  flash_array_model array (.clk_sys(clk_sys), .rst_n(rst_n), .flash_cmd_valid(valid),
    .latency(lat), .flash_cmd_done(done));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Command capture, mid-cycle
  always @(negedge clk_sys)
    if (valid === 1'b1)
    begin
      ops_seen++;
      cap = {cfunc, caddr, clast, cdata};
    end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk({9'h0, rdata & m}, {9'h0, exp}, "read data");
    chk({16'h0, hit}, {16'h0, a == 8'h00_BF || a[7:2] == 6'h3D}, "hit");
  endtask : rd

  task automatic unlock;
    wr(ADDR_FLASH_DATA, UNLOCK_KEY_A);
    wr(ADDR_FLASH_DATA, UNLOCK_KEY_B);
    wr(ADDR_FLASH_DATA, UNLOCK_KEY_A);
  endtask : unlock

  task automatic run_op(input logic [1:0] fn, input logic z, input logic [7:0] hi, lo, d,
                        input logic [7:0] latency);
    logic [16:0] ea;
    logic [16:0] el;
    ea = fn == FUNC_FULL_ERASE ? 17'h0_0000 : {z, hi, lo};
    el = fn != FUNC_FULL_ERASE ? ea + 17'h0_01FF : (lock ? BOOT_BASE - 17'h0_0001 : 17'h1_FFFF);
    ops_seen = 0;
    lat = latency;
    unlock();
    wr(ADDR_SYSTEM_CONTROL, 8'h00_0C);
    wr(ADDR_FLASH_ADDR_HI, hi);
    wr(ADDR_FLASH_ADDR_LO, lo);
    wr(ADDR_FLASH_DATA, d);
    wr(ADDR_FLASH_OP_CTRL, {2'b10, z, 3'b000, fn});
    rd(ADDR_FLASH_OP_CTRL, 8'h00_A3, {2'b10, z, 3'b000, fn});
    chk({16'h0, pc_hold}, 17'h0_0001, "hold");
    chk(17'(ops_seen), 17'h0_0001, "one command");
    chk({15'h0, cap[43:42]}, {15'h0, fn}, "func");
    chk(cap[41:25], ea, "addr");
    chk({9'h0, cap[7:0]}, {9'h0, d}, "data");
    if (fn[1])
      chk(cap[24:8], el, "last");
    for (i = 0; i < 300 && pc_hold !== 1'b0; i++)
      @(negedge clk_sys);
    chk({16'h0, pc_hold}, 17'h0_0000, "release");
    rd(ADDR_FLASH_OP_CTRL, 8'h00_A3, {2'b00, z, 3'b000, fn});
    $display("test op %0d done", fn);
  endtask : run_op

  initial
  begin
    #500000;
    err_total++;
    results();
  end

  initial
  begin
    {rst_n, sfr_wr, sfr_rd, wdt_rst, lock, sfr_addr, sfr_wdata, lat} = '0;
    err_total = 0;
    checks_done = 0;
    ops_seen = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (regs[k])
      rd(regs[k], 8'h00_FF, 8'h00_00);
    rd(8'h00_80, 8'h00_FF, 8'h00_00);
    wr(ADDR_SYSTEM_CONTROL, 8'h00_7F);
    rd(ADDR_SYSTEM_CONTROL, 8'h00_FF, 8'h00_0F);
    chk({13'h0, dfe, spe, xre, lsi}, 17'h0_000F, "enables");
    wr(ADDR_SYSTEM_CONTROL, 8'h00_00);
    chk({13'h0, dfe, spe, xre, lsi}, 17'h0_0000, "disables");
    $display("test registers done");
    wr(ADDR_SYSTEM_CONTROL, 8'h00_04);
    wr(ADDR_FLASH_OP_CTRL, 8'h00_80);
    rd(ADDR_FLASH_OP_CTRL, 8'h00_80, 8'h00_00);
    unlock();
    wr(ADDR_SYSTEM_CONTROL, 8'h00_00);
    wr(ADDR_FLASH_OP_CTRL, 8'h00_80);
    rd(ADDR_FLASH_OP_CTRL, 8'h00_80, 8'h00_00);
    chk(17'(ops_seen), 17'h0_0000, "refused starts");
    $display("test refusals done");
    run_op(FUNC_BYTE_PROGRAM, 1'b0, 8'h00_12, 8'h00_34, 8'h00_A5, 8'h00_04);
    run_op(FUNC_ERASE_PROT, 1'b1, 8'h00_FF, 8'h00_FF, 8'h00_5A, 8'h00_1E);
    run_op(FUNC_PAGE_ERASE, 1'b0, 8'h00_B0, 8'h00_00, 8'h00_00, 8'h00_06);
    run_op(FUNC_FULL_ERASE, 1'b1, 8'h00_00, 8'h00_00, 8'h00_00, 8'h00_32);
    lock = 1'b1;
    run_op(FUNC_FULL_ERASE, 1'b0, 8'h00_00, 8'h00_00, 8'h00_00, 8'h00_08);
    ops_seen = 0;
    unlock();
    wr(ADDR_SYSTEM_CONTROL, 8'h00_04);
    wr(ADDR_FLASH_ADDR_HI, 8'h00_F2);
    wr(ADDR_FLASH_ADDR_LO, 8'h00_00);
    wr(ADDR_FLASH_OP_CTRL, 8'h00_82);
    rd(ADDR_FLASH_OP_CTRL, 8'h00_80, 8'h00_00);
    chk(17'(ops_seen), 17'h0_0000, "boot page erase");
    chk({16'h0, pc_hold}, 17'h0_0000, "boot page hold");
    lock = 1'b0;
    run_op(FUNC_BYTE_PROGRAM, 1'b1, 8'h00_F2, 8'h00_01, 8'h00_3C, 8'h00_05);
    $display("test boot lock done");
    @(negedge clk_sys);
    rst_n = 1'b0;
    wdt_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    {rst_n, wdt_rst} = 2'b10;
    rd(ADDR_SYSTEM_CONTROL, 8'h00_FF, 8'h00_80);
    wr(ADDR_SYSTEM_CONTROL, 8'h00_00);
    rd(ADDR_SYSTEM_CONTROL, 8'h00_FF, 8'h00_00);
    $display("test watchdog flag done");
    results();
  end
endmodule : flash_self_program_ctrl_tb

//--- flash_self_program_pkg.sv
// Constants for the flash self-programming controller
package flash_self_program_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h00_BF;
  localparam logic [7:0] ADDR_FLASH_ADDR_HI  = 8'h00_F4;
  localparam logic [7:0] ADDR_FLASH_ADDR_LO  = 8'h00_F5;
  localparam logic [7:0] ADDR_FLASH_DATA     = 8'h00_F6;
  localparam logic [7:0] ADDR_FLASH_OP_CTRL  = 8'h00_F7;

  // System control fields
  localparam int BIT_WATCHDOG_RESET   = 7;
  localparam int BIT_DATA_FLASH_EN    = 3;
  localparam int BIT_SELF_PROG_EN     = 2;
  localparam int BIT_EXTRA_RAM_EN     = 1;
  localparam int BIT_STROBE_INHIBIT   = 0;

  // Operation control fields
  localparam int BIT_OP_START         = 7;
  localparam int BIT_ZONE_SELECT      = 5;
  localparam int BIT_FUNC_HI          = 1;
  localparam int BIT_FUNC_LO          = 0;

  // Reset values
  localparam logic [7:0] RESET_SYSTEM_CONTROL = 8'h00_00;
  localparam logic [7:0] RESET_BYTE           = 8'h00_00;

  // Unlock key values written to the data register
  localparam logic [7:0] UNLOCK_KEY_A = 8'h00_55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'h00_AA;

  // Page erase geometry
  localparam int PAGE_BYTES = 512;

  // Function codes
  typedef enum logic [1:0]
  {
    FUNC_BYTE_PROGRAM = 2'b00,
    FUNC_ERASE_PROT   = 2'b01,
    FUNC_PAGE_ERASE   = 2'b10,
    FUNC_FULL_ERASE   = 2'b11
  } op_function_code_t;

  // Sequencer states, Gray along idle-issue-wait-done
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b11,
    ST_DONE  = 2'b10
  } seq_state_t;

  // Unlock progress
  typedef enum logic [1:0]
  {
    UL_NONE  = 2'b00,
    UL_ONE   = 2'b01,
    UL_TWO   = 2'b11,
    UL_OPEN  = 2'b10
  } unlock_state_t;

endpackage : flash_self_program_pkg
